// File: design/pdpc_top.sv
// reference and feedback dividers, phase detector and charge pump control, AHB-Lite slave
// Function
// - reference divided by 14-bit ratio 1..16383
// - fractional mode average ratio 36..65535
// - integer mode ratio 32..65567
// - detector compares divided reference and feedback
// - polarity invert swaps up and down
// - cleared up allow blocks up requests
// - cleared down allow blocks down requests
// - both cleared tri-states pump, rest runs
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pdpc_top
   import pdpc_pkg::*;
#(
   parameter int RDIV_W = 14,
   parameter int NDIV_W = 17,
   parameter int FRAC_W = 16
) (
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic                   hready,
   input  wire logic [31:0]            hwdata,
   output logic      [31:0]            hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   input  wire logic                   ref_in,
   input  wire logic                   vco_in,
   output logic                        ref_div_out,
   output logic                        vco_div_out,
   output logic                        cp_up,
   output logic                        cp_down,
   output logic                        cp_oe_n
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0]             ref_s;    // sync pair plus previous
      logic [2:0]             vco_s;
      logic [RDIV_W-1:0]      ref_cnt;
      logic [NDIV_W-1:0]      vco_cnt;
      logic [FRAC_W-1:0]      acc;
      logic                   carry;
      pdpc_pfd_t              pfd;
      logic                   up;
      logic                   dn;
      logic                   hiz;
      logic                   ref_p;
      logic                   vco_p;
      logic [3:0]             ctrl;
      logic [RDIV_W-1:0]      rdiv;
      logic [NDIV_W-1:0]      nint;
      logic [FRAC_W-1:0]      nfrac;
      logic [PDPC_ADDR_W-1:0] wr_addr;
      logic                   wr_pend;
      logic [31:0]            rdata;
   } pdpc_state_t;

   pdpc_state_t s_q;
   pdpc_state_t s_d;

   // clamp a ratio into [lo, hi]
   function automatic logic [NDIV_W-1:0] pdpc_clamp(input logic [NDIV_W-1:0] v,
                                                    input logic [NDIV_W-1:0] lo,
                                                    input logic [NDIV_W-1:0] hi);
      pdpc_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : pdpc_clamp

   logic                   ref_edge;
   logic                   vco_edge;
   logic                   ref_div;
   logic                   vco_div;
   logic [RDIV_W-1:0]      rdiv_eff;
   logic [NDIV_W-1:0]      nint_eff;
   logic [NDIV_W-1:0]      n_eff;
   logic [FRAC_W:0]        acc_sum;
   logic                   frac_mode;
   logic                   raw_up;
   logic                   raw_dn;
   logic                   addr_ok;

   // ---------------------------------------------------------------
   // ratio selection and divider terminal counts
   // ---------------------------------------------------------------
   // edges come from stages 1 and 2 only; stage 0 feeds stage 1 alone
   always_comb begin
      frac_mode = s_q.ctrl[PDPC_CTRL_FRAC_BIT];
      ref_edge  = s_q.ref_s[1] & ~s_q.ref_s[2];
      vco_edge  = s_q.vco_s[1] & ~s_q.vco_s[2];
      rdiv_eff  = (s_q.rdiv < PDPC_RDIV_MIN) ? PDPC_RDIV_MIN : s_q.rdiv;
      if (frac_mode) begin
         nint_eff = pdpc_clamp(s_q.nint, PDPC_NFRAC_MIN, PDPC_NFRAC_INT_MAX);
      end else begin
         nint_eff = pdpc_clamp(s_q.nint, PDPC_NINT_MIN, PDPC_NINT_MAX);
      end
      n_eff   = nint_eff + NDIV_W'(s_q.carry & frac_mode);
      // at or past the end: a ratio lowered mid-count must not strand the counter
      ref_div = ref_edge && (s_q.ref_cnt >= rdiv_eff - RDIV_W'(1));
      vco_div = vco_edge && (s_q.vco_cnt >= n_eff - NDIV_W'(1));
      acc_sum = {1'b0, s_q.acc} + {1'b0, s_q.nfrac};
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d       = s_q;
      s_d.ref_s = {s_q.ref_s[1:0], ref_in};
      s_d.vco_s = {s_q.vco_s[1:0], vco_in};
      s_d.ref_p = ref_div;
      s_d.vco_p = vco_div;

      // dividers free run whatever the pump mask says
      if (ref_edge) begin
         s_d.ref_cnt = ref_div ? '0 : s_q.ref_cnt + RDIV_W'(1);
      end
      if (vco_edge) begin
         s_d.vco_cnt = vco_div ? '0 : s_q.vco_cnt + NDIV_W'(1);
      end
      // first-order accumulator picks N or N+1 for the next cycle
      if (vco_div) begin
         s_d.acc   = frac_mode ? acc_sum[FRAC_W-1:0] : '0;
         s_d.carry = frac_mode & acc_sum[FRAC_W];
      end

      // phase detector: a simultaneous pair cancels at once
      case (s_q.pfd)
         PDPC_IDLE: begin
            if (ref_div && !vco_div) begin
               s_d.pfd = PDPC_UP;
            end else if (vco_div && !ref_div) begin
               s_d.pfd = PDPC_DN;
            end
         end
         PDPC_UP: begin
            if (vco_div) begin
               s_d.pfd = PDPC_IDLE;
            end
         end
         PDPC_DN: begin
            if (ref_div) begin
               s_d.pfd = PDPC_IDLE;
            end
         end
         default: begin
            s_d.pfd = PDPC_IDLE;
         end
      endcase
      raw_up = (s_d.pfd == PDPC_UP);
      raw_dn = (s_d.pfd == PDPC_DN);
      if (s_q.ctrl[PDPC_CTRL_INV_BIT]) begin
         s_d.up = raw_dn & s_q.ctrl[PDPC_CTRL_UP_BIT];
         s_d.dn = raw_up & s_q.ctrl[PDPC_CTRL_DN_BIT];
      end else begin
         s_d.up = raw_up & s_q.ctrl[PDPC_CTRL_UP_BIT];
         s_d.dn = raw_dn & s_q.ctrl[PDPC_CTRL_DN_BIT];
      end
      s_d.hiz = ~(s_q.ctrl[PDPC_CTRL_UP_BIT] | s_q.ctrl[PDPC_CTRL_DN_BIT]);

      // bus write lands in the data phase
      if (s_q.wr_pend) begin
         if (s_q.wr_addr == PDPC_CTRL_OFS) begin
            s_d.ctrl = hwdata[3:0];
         end else if (s_q.wr_addr == PDPC_RDIV_OFS) begin
            s_d.rdiv = hwdata[RDIV_W-1:0];
         end else if (s_q.wr_addr == PDPC_NINT_OFS) begin
            s_d.nint = hwdata[NDIV_W-1:0];
         end else if (s_q.wr_addr == PDPC_NFRAC_OFS) begin
            s_d.nfrac = hwdata[FRAC_W-1:0];
         end
      end

      // address phase; read decode sees a write that lands this cycle
      addr_ok   = hsel && htrans[1] && hready;
      s_d.wr_pend = addr_ok && hwrite && (haddr[31:PDPC_ADDR_W] == '0);
      s_d.wr_addr = haddr[PDPC_ADDR_W-1:0];
      s_d.rdata   = '0;
      if (addr_ok && !hwrite && haddr[31:PDPC_ADDR_W] == '0) begin
         if (haddr[PDPC_ADDR_W-1:0] == PDPC_CTRL_OFS) begin
            s_d.rdata[3:0] = s_d.ctrl;
         end else if (haddr[PDPC_ADDR_W-1:0] == PDPC_RDIV_OFS) begin
            s_d.rdata[RDIV_W-1:0] = s_d.rdiv;
         end else if (haddr[PDPC_ADDR_W-1:0] == PDPC_NINT_OFS) begin
            s_d.rdata[NDIV_W-1:0] = s_d.nint;
         end else if (haddr[PDPC_ADDR_W-1:0] == PDPC_NFRAC_OFS) begin
            s_d.rdata[FRAC_W-1:0] = s_d.nfrac;
         end else if (haddr[PDPC_ADDR_W-1:0] == PDPC_STATUS_OFS) begin
            s_d.rdata[PDPC_STAT_UP_BIT]  = s_q.up;
            s_d.rdata[PDPC_STAT_DN_BIT]  = s_q.dn;
            s_d.rdata[PDPC_STAT_HIZ_BIT] = s_q.hiz;
            s_d.rdata[PDPC_STAT_PFD_LSB +: 2] = s_q.pfd;
            s_d.rdata[PDPC_STAT_RCNT_LSB +: RDIV_W] = s_q.ref_cnt;
         end
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q      <= '0;
         s_q.pfd  <= PDPC_IDLE;
         s_q.ctrl <= PDPC_CTRL_RST;
         s_q.rdiv <= PDPC_RDIV_RST;
         s_q.nint <= PDPC_NINT_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // zero wait states, always OKAY
   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;
   assign hrdata      = s_q.rdata;
   assign ref_div_out = s_q.ref_p;
   assign vco_div_out = s_q.vco_p;
   assign cp_up       = s_q.up;
   assign cp_down     = s_q.dn;
   assign cp_oe_n     = s_q.hiz;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   ref_div_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ref_div |-> ref_edge) else $error("reference divide pulse without edge");
   // a ratio write may leave the count high until the next reference edge
   ref_cnt_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ref_edge && !s_q.wr_pend) |=> s_q.ref_cnt < rdiv_eff)
      else $error("reference count beyond ratio");
   frac_ratio_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      frac_mode |-> (n_eff >= PDPC_NFRAC_MIN && n_eff <= PDPC_NFRAC_AVG_MAX))
      else $error("fractional ratio out of range");
   int_ratio_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !frac_mode |-> (n_eff >= PDPC_NINT_MIN && n_eff <= PDPC_NINT_MAX))
      else $error("integer ratio out of range");
   pfd_up_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (s_q.pfd == PDPC_IDLE && ref_div && !vco_div && s_q.ctrl == PDPC_CTRL_RST)
      |=> cp_up && !cp_down) else $error("reference edge did not raise up");
   pfd_invert_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ($past(s_q.ctrl[PDPC_CTRL_INV_BIT]) && cp_up) |-> s_q.pfd == PDPC_DN)
      else $error("inverted up not from down state");
   up_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cp_up |-> $past(s_q.ctrl[PDPC_CTRL_UP_BIT])) else $error("up while masked");
   dn_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cp_down |-> $past(s_q.ctrl[PDPC_CTRL_DN_BIT])) else $error("down while masked");
   pump_hiz_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cp_oe_n == !($past(s_q.ctrl[PDPC_CTRL_UP_BIT]) || $past(s_q.ctrl[PDPC_CTRL_DN_BIT])))
      else $error("pump enable does not follow masks");
   pfd_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (s_q.pfd == PDPC_UP && vco_div) |=> s_q.pfd == PDPC_IDLE)
      else $error("up request not cleared");
endmodule : pdpc_top
`default_nettype wire

// File: design/pdpc_pkg.sv
// shared constants and types for the divider and phase detector control block
package pdpc_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] PDPC_CTRL_OFS   = 8'h00;
   localparam logic [7:0] PDPC_RDIV_OFS   = 8'h04;
   localparam logic [7:0] PDPC_NINT_OFS   = 8'h08;
   localparam logic [7:0] PDPC_NFRAC_OFS  = 8'h0C;
   localparam logic [7:0] PDPC_STATUS_OFS = 8'h10;
   localparam int         PDPC_ADDR_W     = 8;

   // ---------------------------------------------------------------
   // control field positions and reset values
   // ---------------------------------------------------------------
   localparam int PDPC_CTRL_FRAC_BIT  = 0;   // fractional mode
   localparam int PDPC_CTRL_INV_BIT   = 1;   // detector polarity invert
   localparam int PDPC_CTRL_UP_BIT    = 2;   // up request allow
   localparam int PDPC_CTRL_DN_BIT    = 3;   // down request allow
   localparam logic [3:0]  PDPC_CTRL_RST  = 4'hC;
   localparam logic [13:0] PDPC_RDIV_RST  = 14'h0001;
   localparam logic [16:0] PDPC_NINT_RST  = 17'h0_0064;

   // status field positions
   localparam int PDPC_STAT_UP_BIT    = 0;
   localparam int PDPC_STAT_DN_BIT    = 1;
   localparam int PDPC_STAT_HIZ_BIT   = 2;
   localparam int PDPC_STAT_PFD_LSB   = 4;
   localparam int PDPC_STAT_RCNT_LSB  = 16;

   // ---------------------------------------------------------------
   // divide ratio limits
   // ---------------------------------------------------------------
   localparam logic [13:0] PDPC_RDIV_MIN      = 14'h0001;
   localparam logic [16:0] PDPC_NFRAC_MIN     = 17'h0_0024; // 36
   localparam logic [16:0] PDPC_NFRAC_INT_MAX = 17'h0_FFFE; // plus carry gives 65,535
   localparam logic [16:0] PDPC_NFRAC_AVG_MAX = 17'h0_FFFF; // 65,535
   localparam logic [16:0] PDPC_NINT_MIN      = 17'h0_0020; // 32
   localparam logic [16:0] PDPC_NINT_MAX      = 17'h1_001F; // 65,567

   // detector states, gray along idle-up and idle-down paths
   typedef enum logic [1:0] {
      PDPC_IDLE = 2'b00,
      PDPC_UP   = 2'b01,
      PDPC_DN   = 2'b10
   } pdpc_pfd_t;
endpackage : pdpc_pkg

// File: verif/pdpc_osc_model.sv
// burst oscillator standing in for the reference source or the external vco
`timescale 1ns/1ps
`default_nettype none
module pdpc_osc_model (
   input  wire logic        sys_clk,
   input  wire logic        go,
   input  wire logic [15:0] n_edges,
   input  wire logic [15:0] half,
   output var  logic        line,
   output var  logic        busy
);
   logic [15:0] left_q;
   logic [15:0] cnt_q;
   // -----------------------------------------------
   // burst of rising edges, line parks low between bursts
   // -----------------------------------------------
   // half is held at 2 or more so the two-flop synchroniser sees every level
   initial begin
      line = 1'b0;
      busy = 1'b0;
      left_q = '0;
      cnt_q = '0;
   end
   always @(posedge sys_clk) begin
      if (go && !busy) begin
         left_q <= n_edges;
         cnt_q <= '0;
         busy <= 1'b1;
      end else if (busy) begin
         if (cnt_q == half - 16'h0001) begin
            cnt_q <= '0;
            if (line) begin
               line <= 1'b0;
               busy <= (left_q != '0);
            end else if (left_q != '0) begin
               line <= 1'b1;
               left_q <= left_q - 16'h0001;
            end
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end
endmodule : pdpc_osc_model
`default_nettype wire

// File: verif/tb_pll_divider_pfd_control.sv
// register, divider and phase detector checks for the synthesizer control block
`timescale 1ns/1ps
`default_nettype none
module tb_pll_divider_pfd_control;
   import pdpc_pkg::*;
   logic sys_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic ref_in, vco_in, ref_div_out, vco_div_out, cp_up, cp_down, cp_oe_n;
   logic go_r, go_v, busy_r, busy_v;
   logic [15:0] n_r, n_v, h_r, h_v;
   int n_fail, n_tests, c_rdiv, c_vdiv, c_up, c_dn, c_hiz;
   logic [3:0] ctrl_tab [6] = '{4'h0C, 4'h0E, 4'h08, 4'h04, 4'h06, 4'h00};

   assign hready = hreadyout;
   pdpc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ref_in(ref_in),
      .vco_in(vco_in), .ref_div_out(ref_div_out), .vco_div_out(vco_div_out),
      .cp_up(cp_up), .cp_down(cp_down), .cp_oe_n(cp_oe_n));
   pdpc_osc_model ref_m (.sys_clk(sys_clk), .go(go_r), .n_edges(n_r), .half(h_r),
      .line(ref_in), .busy(busy_r));
   pdpc_osc_model vco_m (.sys_clk(sys_clk), .go(go_v), .n_edges(n_v), .half(h_v),
      .line(vco_in), .busy(busy_v));

   // -----------------------------------------------
   // clock and output activity counters
   // -----------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      c_rdiv += (ref_div_out === 1'b1);
      c_vdiv += (vco_div_out === 1'b1);
      c_up += (cp_up === 1'b1);
      c_dn += (cp_down === 1'b1);
      c_hiz += (cp_oe_n === 1'b1);
   end

   // -----------------------------------------------
   // helper tasks
   // -----------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   // bounded wait for hready sampled high at a rising edge
   task automatic wait_rdy();
      int i;
      for (i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         if (hready === 1'b1) return;
      end
      n_fail++;
      conclude();
   endtask : wait_rdy
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask : bus
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
   endtask : do_reset
   // each source given a nonzero edge count runs a burst; counters are read as differences afterwards
   task automatic burst(input int nr, input int nv);
      int i;
      n_r <= 16'(nr);
      n_v <= 16'(nv);
      go_r <= (nr != 0);
      go_v <= (nv != 0);
      @(posedge sys_clk);
      go_r <= 1'b0;
      go_v <= 1'b0;
      @(posedge sys_clk);
      for (i = 0; busy_r || busy_v; i++) begin
         if (i > 5000) begin
            n_fail++;
            conclude();
         end
         @(posedge sys_clk);
      end
      repeat (8) @(posedge sys_clk);
   endtask : burst

   // -----------------------------------------------
   // main sequence
   // -----------------------------------------------
   initial begin
      int b_r, b_v, b_u, b_d, b_h;
      {rst_n, hwrite, go_r, go_v, htrans, haddr, hwdata} = '0;
      hsel = 1'b1;
      hsize = 3'b010;
      {n_r, n_v} = '0;
      h_r = 16'h0002;
      h_v = 16'h0002;
      {n_fail, n_tests, c_rdiv, c_vdiv, c_up, c_dn, c_hiz} = '0;
      do_reset();
      // reset values and register access
      bus(0, 32'(PDPC_CTRL_OFS), '0); check(rd, 32'h0000_000C);
      check(32'(hresp), 32'h0000_0000);
      bus(0, 32'(PDPC_RDIV_OFS), '0); check(rd, 32'h0000_0001);
      bus(0, 32'(PDPC_NINT_OFS), '0); check(rd, 32'h0000_0064);
      bus(0, 32'(PDPC_NFRAC_OFS), '0); check(rd, 32'h0000_0000);
      bus(1, 32'(PDPC_RDIV_OFS), 32'hFFFF_FFFF);
      bus(0, 32'(PDPC_RDIV_OFS), '0); check(rd, 32'h0000_3FFF);
      bus(1, 32'h0000_0014, 32'h1234_5678);
      bus(0, 32'h0000_0014, '0); check(rd, 32'h0000_0000);
      // reference divider by three: 30 edges give 10 pulses
      do_reset();
      bus(1, 32'(PDPC_RDIV_OFS), 32'h0000_0003);
      b_r = c_rdiv; burst(30, 0); check(32'(c_rdiv - b_r), 32'd10);
      // integer mode at the minimum ratio, and a ratio below it held at 32
      do_reset();
      bus(1, 32'(PDPC_NINT_OFS), 32'h0000_0020);
      b_v = c_vdiv; burst(0, 64); check(32'(c_vdiv - b_v), 32'd2);
      do_reset();
      bus(1, 32'(PDPC_NINT_OFS), 32'h0000_0014);
      b_v = c_vdiv; burst(0, 64); check(32'(c_vdiv - b_v), 32'd2);
      // fractional 36.5 average: 73 edges give exactly 2 pulses
      do_reset();
      bus(1, 32'(PDPC_CTRL_OFS), 32'h0000_000D);
      bus(1, 32'(PDPC_NINT_OFS), 32'h0000_0024);
      bus(1, 32'(PDPC_NFRAC_OFS), 32'h0000_8000);
      b_v = c_vdiv; burst(0, 73); check(32'(c_vdiv - b_v), 32'd2);
      // third cycle takes the carry: 108 edges still give 2, the 109th gives 3
      burst(0, 35);
      check(32'(c_vdiv - b_v), 32'd2);
      burst(0, 1);
      check(32'(c_vdiv - b_v), 32'd3);
      // reference leads feedback: up request, shaped by invert and masks
      foreach (ctrl_tab[k]) begin
         do_reset();
         bus(1, 32'(PDPC_NINT_OFS), 32'h0000_0020);
         bus(1, 32'(PDPC_CTRL_OFS), 32'(ctrl_tab[k]));
         {b_r, b_u, b_d, b_h} = {c_rdiv, c_up, c_dn, c_hiz};
         burst(40, 64);
         check(32'(c_up > b_u), 32'(!ctrl_tab[k][1] && ctrl_tab[k][2]));
         check(32'(c_dn > b_d), 32'(ctrl_tab[k][1] && ctrl_tab[k][3]));
         check(32'(c_hiz > b_h), 32'(ctrl_tab[k][3:2] == 2'b00));
         check(32'(c_rdiv - b_r), 32'd40);
         // feedback leads: down request stands until a reference edge clears it
         {b_u, b_d} = {c_up, c_dn};
         burst(0, 32);
         bus(0, 32'(PDPC_STATUS_OFS), '0);
         check(rd, {26'h0, 2'b10, 1'b0, 1'(ctrl_tab[k][3:2] == 2'b00),
            1'(!ctrl_tab[k][1] && ctrl_tab[k][3]), 1'(ctrl_tab[k][1] && ctrl_tab[k][2])});
         burst(1, 0);
         check(32'(c_up > b_u), 32'(ctrl_tab[k][1] && ctrl_tab[k][2]));
         check(32'(c_dn > b_d), 32'(!ctrl_tab[k][1] && ctrl_tab[k][3]));
         bus(0, 32'(PDPC_STATUS_OFS), '0);
         check(rd, {29'h0, 1'(ctrl_tab[k][3:2] == 2'b00), 2'b00});
      end
      conclude();
   end
endmodule : tb_pll_divider_pfd_control
`default_nettype wire
